// File: sgc_pkg.sv
// Constants for the switch global control register bank
package sgc_pkg;
    // Register offsets on the management port
    localparam logic [7:0] GC1_ADDR = 8'h03;
    localparam logic [7:0] GC2_ADDR = 8'h04;
    // Field positions, global control one
    localparam int GC1_PASS_ALL = 7;
    localparam int GC1_JUMBO_2K = 6;
    localparam int GC1_TX_FC_DIS = 5;
    localparam int GC1_RX_FC_DIS = 4;
    localparam int GC1_LEN_CHECK = 3;
    localparam int GC1_AGE_EN = 2;
    localparam int GC1_FAST_AGE = 1;
    localparam int GC1_AGGR_BO = 0;
    // Field positions, global control two
    localparam int GC2_VLAN_DISCARD = 7;
    localparam int GC2_MCAST_STORM_DIS = 6;
    // Reset values; strap-driven bits are zero here and patched from the straps
    localparam logic [7:0] GC1_RESET = 8'h04;
    localparam logic [7:0] GC2_RESET = 8'hC0;
    // Only the top two bits of the second register live in this block
    localparam logic [7:0] GC2_IMPL_MASK = 8'hC0;
    // Frame length limits
    localparam logic [15:0] LEN_FIELD_LIMIT = 16'h05DC;
    localparam logic [11:0] JUMBO_MAX_LEN = 12'h800;
    localparam logic [11:0] LEGACY_MAX_LEN = 12'h5EE;
    // Timing
    localparam longint CLK_HZ = 64'h2FAF080;
    localparam longint FAST_AGE_US = 64'h320;
    localparam longint NORMAL_AGE_S = 64'h12C;
    localparam logic [35:0] FAST_AGE_CYC = 36'(FAST_AGE_US * CLK_HZ / 64'hF4240);
    localparam logic [35:0] NORMAL_AGE_CYC = 36'(NORMAL_AGE_S * CLK_HZ);
    localparam int SYNC_STAGES = 2;
endpackage : sgc_pkg

// File: sgc_sync.sv
// Two-stage synchroniser for a strap pin
module sgc_sync (
    input wire logic clk, // System clock
    input wire logic pin_in, // Asynchronous pin level
    output logic level_out // Synchronised level
);
    logic [sgc_pkg::SYNC_STAGES-1:0] stage_q;

    // Not reset: must keep tracking the pin while reset is held
    always_ff @(posedge clk) begin
        stage_q <= {stage_q[sgc_pkg::SYNC_STAGES-2:0], pin_in};
    end

    assign level_out = stage_q[sgc_pkg::SYNC_STAGES-1];
endmodule : sgc_sync

// File: sgc_regs.sv
// Global control register bank of the four-port switch
module sgc_regs #(
    parameter logic [35:0] FAST_AGE_CYCLES = sgc_pkg::FAST_AGE_CYC,
    parameter logic [35:0] NORMAL_AGE_CYCLES = sgc_pkg::NORMAL_AGE_CYC
) (
    input wire logic clk, // System clock
    input wire logic sys_rst, // Synchronous reset, active high
    input wire logic flow_control_strap_pin, // Strap: pause disable default
    input wire logic backoff_strap_pin, // Strap: aggressive back-off default
    input wire logic [7:0] reg_addr, // Management register address
    input wire logic reg_wr, // Write strobe
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic reg_rd, // Read strobe
    output logic [7:0] reg_rdata, // Read data
    output logic reg_rvalid, // Read data valid pulse
    input wire logic an_tx_pause, // Negotiated transmit pause
    input wire logic an_rx_pause, // Negotiated receive pause
    input wire logic half_duplex, // Port runs half duplex
    input wire logic pkt_valid, // Frame descriptor valid
    input wire logic [15:0] pkt_len_type, // Length/type field
    input wire logic [15:0] pkt_actual_len, // Measured payload length
    input wire logic [11:0] pkt_frame_len, // Whole frame length in bytes
    input wire logic pkt_bad, // Frame has an error
    input wire logic pkt_cross_vlan, // Egress outside port VLAN
    input wire logic pkt_known_ucast, // Known unicast destination
    input wire logic pkt_bcast, // All-ones destination
    input wire logic pkt_mcast, // Multicast destination
    output logic tx_fc_enable, // Transmit pause active
    output logic rx_fc_enable, // Receive pause active
    output logic aggr_backoff, // Aggressive back-off active
    output logic jumbo_enable, // 2K frames accepted
    output logic age_tick, // Aging sweep pulse
    output logic frame_drop, // Drop decision pulse
    output logic vlan_block, // VLAN boundary block pulse
    output logic storm_count // Count toward storm limit pulse
);
    logic fc_strap;
    logic bo_strap;
    logic [7:0] gc1_q;
    logic [7:0] gc2_q;
    logic [7:0] rdata_q;
    logic rvalid_q;
    logic tx_fc_q;
    logic rx_fc_q;
    logic aggr_q;
    logic [35:0] age_cnt_q;
    logic age_tick_q;
    logic drop_q;
    logic vblock_q;
    logic storm_q;
    logic [35:0] age_period;
    logic len_bad;
    logic too_long;

    sgc_sync u_fc_sync (
        .clk(clk),
        .pin_in(flow_control_strap_pin),
        .level_out(fc_strap)
    );

    sgc_sync u_bo_sync (
        .clk(clk),
        .pin_in(backoff_strap_pin),
        .level_out(bo_strap)
    );

    // Strap bits follow the pin during reset and hold it at release
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            gc1_q <= sgc_pkg::GC1_RESET;
            gc1_q[sgc_pkg::GC1_TX_FC_DIS] <= fc_strap;
            gc1_q[sgc_pkg::GC1_RX_FC_DIS] <= fc_strap;
            gc1_q[sgc_pkg::GC1_AGGR_BO] <= bo_strap;
        end else if (reg_wr && reg_addr == sgc_pkg::GC1_ADDR) begin
            gc1_q <= reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            gc2_q <= sgc_pkg::GC2_RESET;
        end else if (reg_wr && reg_addr == sgc_pkg::GC2_ADDR) begin
            gc2_q <= reg_wdata & sgc_pkg::GC2_IMPL_MASK;
        end
    end

    // Unmapped addresses read as zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= reg_rd;
            if (reg_rd) begin
                case (reg_addr)
                    sgc_pkg::GC1_ADDR: rdata_q <= gc1_q;
                    sgc_pkg::GC2_ADDR: rdata_q <= gc2_q;
                    default: rdata_q <= 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tx_fc_q <= 1'b0;
            rx_fc_q <= 1'b0;
            aggr_q <= 1'b0;
        end else begin
            tx_fc_q <= an_tx_pause & ~gc1_q[sgc_pkg::GC1_TX_FC_DIS];
            rx_fc_q <= an_rx_pause & ~gc1_q[sgc_pkg::GC1_RX_FC_DIS];
            aggr_q <= gc1_q[sgc_pkg::GC1_AGGR_BO] & half_duplex;
        end
    end

    // A long count from normal mode ends at once when fast aging turns on
    assign age_period = gc1_q[sgc_pkg::GC1_FAST_AGE] ? FAST_AGE_CYCLES : NORMAL_AGE_CYCLES;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            age_cnt_q <= 36'h000000000;
            age_tick_q <= 1'b0;
        end else if (!gc1_q[sgc_pkg::GC1_AGE_EN]) begin
            age_cnt_q <= 36'h000000000;
            age_tick_q <= 1'b0;
        end else if (age_cnt_q >= age_period - 36'h000000001) begin
            age_cnt_q <= 36'h000000000;
            age_tick_q <= 1'b1;
        end else begin
            age_cnt_q <= age_cnt_q + 36'h000000001;
            age_tick_q <= 1'b0;
        end
    end

    assign len_bad = gc1_q[sgc_pkg::GC1_LEN_CHECK] && pkt_len_type < sgc_pkg::LEN_FIELD_LIMIT
                     && pkt_len_type != pkt_actual_len;
    assign too_long = pkt_frame_len > (gc1_q[sgc_pkg::GC1_JUMBO_2K] ? sgc_pkg::JUMBO_MAX_LEN
                                                                    : sgc_pkg::LEGACY_MAX_LEN);

    // Pass-all overrides every frame_drop reason but not the VLAN block; debug use only
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            drop_q <= 1'b0;
            vblock_q <= 1'b0;
            storm_q <= 1'b0;
        end else begin
            drop_q <= pkt_valid && !gc1_q[sgc_pkg::GC1_PASS_ALL] && (len_bad || too_long || pkt_bad);
            vblock_q <= pkt_valid && pkt_cross_vlan
                        && (gc2_q[sgc_pkg::GC2_VLAN_DISCARD] || !pkt_known_ucast);
            storm_q <= pkt_valid && (pkt_bcast
                        || (pkt_mcast && !gc2_q[sgc_pkg::GC2_MCAST_STORM_DIS]));
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;
    assign tx_fc_enable = tx_fc_q;
    assign rx_fc_enable = rx_fc_q;
    assign aggr_backoff = aggr_q;
    assign jumbo_enable = gc1_q[sgc_pkg::GC1_JUMBO_2K];
    assign age_tick = age_tick_q;
    assign frame_drop = drop_q;
    assign vlan_block = vblock_q;
    assign storm_count = storm_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_pass_all;
        pkt_valid && pkt_bad && gc1_q[sgc_pkg::GC1_PASS_ALL] |=> !frame_drop;
    endproperty
    a_pass_all: assert property (p_pass_all) else $error("bad frame dropped in pass-all");

    property p_jumbo;
        pkt_valid && !gc1_q[sgc_pkg::GC1_PASS_ALL] && !gc1_q[sgc_pkg::GC1_JUMBO_2K]
            && pkt_frame_len == sgc_pkg::JUMBO_MAX_LEN |=> frame_drop;
    endproperty
    a_jumbo: assert property (p_jumbo) else $error("2K frame kept while disabled");

    property p_tx_fc;
        $past(gc1_q[sgc_pkg::GC1_TX_FC_DIS]) |-> !tx_fc_enable;
    endproperty
    a_tx_fc: assert property (p_tx_fc) else $error("tx pause on while disabled");

    property p_rx_fc;
        // Output is still the reset value in the first cycle after release
        !$past(sys_rst) && !$past(gc1_q[sgc_pkg::GC1_RX_FC_DIS]) |-> rx_fc_enable == $past(an_rx_pause);
    endproperty
    a_rx_fc: assert property (p_rx_fc) else $error("rx pause not following negotiation");

    property p_strap_pair;
        $fell(sys_rst) |-> gc1_q[sgc_pkg::GC1_TX_FC_DIS] == gc1_q[sgc_pkg::GC1_RX_FC_DIS];
    endproperty
    a_strap_pair: assert property (p_strap_pair) else $error("pause bits differ after reset");

    property p_len_check;
        pkt_valid && gc1_q[sgc_pkg::GC1_LEN_CHECK] && !gc1_q[sgc_pkg::GC1_PASS_ALL]
            && pkt_len_type < sgc_pkg::LEN_FIELD_LIMIT && pkt_len_type != pkt_actual_len |=> frame_drop;
    endproperty
    a_len_check: assert property (p_len_check) else $error("length mismatch not dropped");

    property p_age_off;
        !gc1_q[sgc_pkg::GC1_AGE_EN] |=> !age_tick ##1 !age_tick;
    endproperty
    a_age_off: assert property (p_age_off) else $error("aging tick while disabled");

    property p_fast_age;
        gc1_q[sgc_pkg::GC1_AGE_EN] && gc1_q[sgc_pkg::GC1_FAST_AGE] && $past(gc1_q[sgc_pkg::GC1_FAST_AGE])
            |-> age_cnt_q < FAST_AGE_CYCLES;
    endproperty
    a_fast_age: assert property (p_fast_age) else $error("fast age period exceeded");

    property p_backoff;
        !half_duplex |=> !aggr_backoff;
    endproperty
    a_backoff: assert property (p_backoff) else $error("aggressive back-off in full duplex");

    property p_vlan_all;
        pkt_valid && pkt_cross_vlan && gc2_q[sgc_pkg::GC2_VLAN_DISCARD] |=> vlan_block;
    endproperty
    a_vlan_all: assert property (p_vlan_all) else $error("cross-VLAN frame not blocked");

    property p_vlan_ucast;
        pkt_valid && pkt_cross_vlan && !gc2_q[sgc_pkg::GC2_VLAN_DISCARD] |=> vlan_block == !$past(pkt_known_ucast);
    endproperty
    a_vlan_ucast: assert property (p_vlan_ucast) else $error("unicast VLAN crossing wrong");

    property p_storm;
        pkt_valid && pkt_mcast && !pkt_bcast && gc2_q[sgc_pkg::GC2_MCAST_STORM_DIS] |=> !storm_count;
    endproperty
    a_storm: assert property (p_storm) else $error("multicast counted as storm");

    property p_write;
        reg_wr && reg_addr == sgc_pkg::GC1_ADDR |=> gc1_q == $past(reg_wdata);
    endproperty
    a_write: assert property (p_write) else $error("write did not override strap bits");

    c_age_tick: cover property (gc1_q[sgc_pkg::GC1_FAST_AGE] && age_tick);
    c_vlan_cross: cover property (pkt_valid && pkt_cross_vlan && pkt_known_ucast ##1 !vlan_block);
    c_len_drop: cover property (pkt_valid && len_bad ##1 frame_drop);
    c_read: cover property (reg_rd && reg_addr == sgc_pkg::GC2_ADDR ##1 reg_rvalid);
endmodule : sgc_regs

// File: test_switch_global_control_regs.sv
// Self-checking bench for the switch global control register bank
module test_switch_global_control_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, sys_rst, flow_control_strap_pin, backoff_strap_pin;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic reg_wr, reg_rd, reg_rvalid, an_tx_pause, an_rx_pause, half_duplex, pkt_valid;
    logic [15:0] pkt_len_type, pkt_actual_len;
    logic [11:0] pkt_frame_len;
    logic pkt_bad, pkt_cross_vlan, pkt_known_ucast, pkt_bcast, pkt_mcast;
    logic tx_fc_enable, rx_fc_enable, aggr_backoff, jumbo_enable, age_tick, frame_drop, vlan_block, storm_count;
    int n_fail = 0;
    int comparisons = 0;
    int cyc = 0;
    // Short aging periods keep the run brief
    sgc_regs #(.FAST_AGE_CYCLES(36'h8), .NORMAL_AGE_CYCLES(36'h14)) u_dut (.clk(clk), .sys_rst(sys_rst),
        .flow_control_strap_pin(flow_control_strap_pin), .backoff_strap_pin(backoff_strap_pin),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .an_tx_pause(an_tx_pause), .an_rx_pause(an_rx_pause), .half_duplex(half_duplex),
        .pkt_valid(pkt_valid), .pkt_len_type(pkt_len_type), .pkt_actual_len(pkt_actual_len),
        .pkt_frame_len(pkt_frame_len), .pkt_bad(pkt_bad), .pkt_cross_vlan(pkt_cross_vlan),
        .pkt_known_ucast(pkt_known_ucast), .pkt_bcast(pkt_bcast), .pkt_mcast(pkt_mcast),
        .tx_fc_enable(tx_fc_enable), .rx_fc_enable(rx_fc_enable), .aggr_backoff(aggr_backoff),
        .jumbo_enable(jumbo_enable), .age_tick(age_tick), .frame_drop(frame_drop), .vlan_block(vlan_block),
        .storm_count(storm_count));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic summarize;
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize
    // Hang guard, well above the expected run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            summarize();
        end
    end
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        chk("read valid", 16'h0001, {15'h0000, reg_rvalid});
        chk("read data", {8'h00, exp}, {8'h00, reg_rdata});
        @(negedge clk);
        chk("read valid end", 16'h0000, {15'h0000, reg_rvalid});
    endtask : rd
    // Expected order: transmit pause, receive pause, back-off
    task automatic lv(input logic [2:0] exp);
        @(negedge clk);
        chk("pause and back-off", {13'h0000, exp}, {13'h0000, tx_fc_enable, rx_fc_enable, aggr_backoff});
    endtask : lv
    // Expected order: drop, VLAN block, storm count
    task automatic pkt(input logic bad, input logic [15:0] lt, input logic [15:0] al, input logic [11:0] fl,
                       input logic cr, input logic ku, input logic bc, input logic mc, input logic [2:0] exp);
        @(negedge clk);
        {pkt_valid, pkt_bad, pkt_len_type, pkt_actual_len, pkt_frame_len} = {1'b1, bad, lt, al, fl};
        {pkt_cross_vlan, pkt_known_ucast, pkt_bcast, pkt_mcast} = {cr, ku, bc, mc};
        @(negedge clk);
        pkt_valid = 1'b0;
        chk("packet decision", {13'h0000, exp}, {13'h0000, frame_drop, vlan_block, storm_count});
    endtask : pkt
    task automatic ages(input logic [7:0] exp);
        logic [7:0] cnt;
        repeat (25) @(negedge clk);
        cnt = 8'h00;
        repeat (80) begin
            @(negedge clk);
            if (age_tick === 1'b1) cnt++;
        end
        chk("age ticks", {8'h00, exp}, {8'h00, cnt});
    endtask : ages
    initial begin
        {sys_rst, flow_control_strap_pin, backoff_strap_pin, reg_wr, reg_rd} = 5'h1F;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h00000;
        {an_tx_pause, an_rx_pause, half_duplex, pkt_valid, pkt_bad} = 5'h1C;
        {pkt_len_type, pkt_actual_len, pkt_frame_len} = 44'h0;
        {pkt_cross_vlan, pkt_known_ucast, pkt_bcast, pkt_mcast} = 4'h0;
        repeat (8) @(negedge clk);
        sys_rst = 1'b0;
        // Straps change after release; the captured level must hold
        {flow_control_strap_pin, backoff_strap_pin} = 2'b00;
        repeat (4) @(negedge clk);
        rd(8'h03, 8'h35);
        rd(8'h04, 8'hC0);
        chk("jumbo", 16'h0000, {15'h0000, jumbo_enable});
        lv(3'b001);
        wr(8'h03, 8'h14);
        lv(3'b100);
        an_tx_pause = 1'b0;
        lv(3'b000);
        an_tx_pause = 1'b1;
        wr(8'h03, 8'h21);
        lv(3'b011);
        half_duplex = 1'b0;
        lv(3'b010);
        rd(8'h05, 8'h00);
        wr(8'h04, 8'hFF);
        rd(8'h04, 8'hC0);
        wr(8'h04, 8'h00);
        rd(8'h04, 8'h00);
        wr(8'h03, 8'h00);
        pkt(1'b0, 16'h0064, 16'h0063, 12'h5EE, 1'b1, 1'b0, 1'b0, 1'b1, 3'b011);
        pkt(1'b0, 16'h0000, 16'h0000, 12'h5EF, 1'b1, 1'b1, 1'b0, 1'b0, 3'b100);
        pkt(1'b1, 16'h0000, 16'h0000, 12'h040, 1'b0, 1'b0, 1'b1, 1'b0, 3'b101);
        wr(8'h03, 8'h08);
        pkt(1'b0, 16'h0064, 16'h0063, 12'h040, 1'b0, 1'b0, 1'b0, 1'b0, 3'b000 | 3'b100);
        pkt(1'b0, 16'h05DC, 16'h0063, 12'h040, 1'b0, 1'b0, 1'b0, 1'b0, 3'b000);
        pkt(1'b0, 16'h05DB, 16'h05DB, 12'h040, 1'b0, 1'b0, 1'b0, 1'b0, 3'b000);
        wr(8'h03, 8'h40);
        chk("jumbo", 16'h0001, {15'h0000, jumbo_enable});
        pkt(1'b0, 16'h0000, 16'h0000, 12'h800, 1'b0, 1'b0, 1'b0, 1'b0, 3'b000);
        pkt(1'b0, 16'h0000, 16'h0000, 12'h801, 1'b0, 1'b0, 1'b0, 1'b0, 3'b100);
        wr(8'h03, 8'hC8);
        pkt(1'b1, 16'h0064, 16'h0063, 12'hFFF, 1'b0, 1'b0, 1'b0, 1'b0, 3'b000);
        wr(8'h04, 8'hC0);
        pkt(1'b0, 16'h0000, 16'h0000, 12'h040, 1'b1, 1'b1, 1'b0, 1'b1, 3'b010);
        pkt(1'b0, 16'h0000, 16'h0000, 12'h040, 1'b0, 1'b0, 1'b1, 1'b0, 3'b001);
        ages(8'h00);
        wr(8'h03, 8'h04);
        ages(8'h04);
        wr(8'h03, 8'h06);
        ages(8'h0A);
        // Second reset with straps low
        @(negedge clk);
        sys_rst = 1'b1;
        repeat (8) @(negedge clk);
        sys_rst = 1'b0;
        rd(8'h03, 8'h04);
        summarize();
    end
endmodule : test_switch_global_control_regs
